// ===== inc/csrl_pkg.sv
// Package for the comparator set-reset latch: register map, fields, resets.
// Assumes a 32-bit AXI4-Lite bus; registers occupy the low byte of a word.
package csrl_pkg;
   localparam logic [3:0] CSRL_OFS_CONTROL = 4'h0;
   localparam logic [3:0] CSRL_OFS_PRESCALE = 4'h4;
   localparam int CSRL_BIT_SET_CLOCK_ENABLE = 0;
   localparam int CSRL_BIT_RESET_PULSE = 2;
   localparam int CSRL_BIT_SET_PULSE = 3;
   localparam int CSRL_BIT_CMP2_RESET_EN = 4;
   localparam int CSRL_BIT_CMP1_SET_EN = 5;
   localparam int CSRL_BIT_FIRST_OUT_SEL = 6;
   localparam int CSRL_BIT_SECOND_OUT_SEL = 7;
   localparam int CSRL_BIT_DIVIDER_LO = 6;
   localparam logic [7:0] CSRL_CONTROL_RESET = 8'h00;
   localparam logic [1:0] CSRL_DIVIDER_RESET = 2'h0;
   localparam logic [6:0] CSRL_DIV_MAX_16 = 7'h0f;
   localparam logic [6:0] CSRL_DIV_MAX_32 = 7'h1f;
   localparam logic [6:0] CSRL_DIV_MAX_64 = 7'h3f;
   localparam logic [6:0] CSRL_DIV_MAX_128 = 7'h7f;
   localparam logic [1:0] CSRL_RESP_OKAY = 2'h0;
   localparam logic [1:0] CSRL_RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic second_out_select;
      logic first_out_select;
      logic cmp1_set_enable;
      logic cmp2_reset_enable;
      logic set_clock_enable;
   } csrl_ctrl_s;
endpackage : csrl_pkg

// ===== core/csrl_latch.sv
// Comparator set-reset latch with output routing and prescaled set clock.
// Assumes comparator levels and pin direction inputs synchronous to i_sys_clk.
//
// Contract
// - Latch holds state without a clock; set and reset are active high.
// - Comparator 1 sets latch when enabled, or software set pulse.
// - Comparator 2 resets latch when enabled, or software reset pulse.
// - Set and reset together leave the latch reset.
// - Writing one to a pulse bit fires one pulse, then clears; zero does nothing.
// - Bit 6 routes Q to output one, bit 7 routes Q-bar to output two.
// - After reset, both pins carry the comparator outputs directly.
// - A pin is driven only with its output enable set and direction output.
// - Latch and routing work whether comparators are enabled or not.
// - Divider code 00/01/10/11 gives oscillator over 16/32/64/128.
// - Unimplemented bits read zero: prescale bits 5-0, control bit 1.
// - Set clock enable pulses latch set periodically; disabled means no pulses.
module csrl_latch (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   // AXI4-Lite write address and data
   input wire logic [3:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   // AXI4-Lite write response
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   // AXI4-Lite read
   input wire logic [3:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   // Comparators and pin logic
   input wire logic i_cmp1_output,
   input wire logic i_cmp2_output,
   input wire logic [1:0] i_cmp_pin_output_enable,
   input wire logic [1:0] i_pin_direction,
   output logic [1:0] o_pin_out,
   output logic [1:0] o_pin_oe,
   output logic o_latch_q
);
   csrl_pkg::csrl_ctrl_s ctrl_q;
   logic [1:0] divider_q;
   logic set_pulse_q;
   logic reset_pulse_q;
   logic [6:0] div_cnt_q;
   logic clk_pulse_q;
   logic latch_q;
   logic aw_held_q;
   logic w_held_q;
   logic [3:0] awaddr_q;
   logic [7:0] wdata_q;
   logic wstrb0_q;
   logic period_upset_q;

   function automatic logic [6:0] div_max(input logic [1:0] code);
      case (code)
         2'h0: div_max = csrl_pkg::CSRL_DIV_MAX_16;
         2'h1: div_max = csrl_pkg::CSRL_DIV_MAX_32;
         2'h2: div_max = csrl_pkg::CSRL_DIV_MAX_64;
         default: div_max = csrl_pkg::CSRL_DIV_MAX_128;
      endcase
   endfunction : div_max

   // Write channel: address and data may arrive in either order
   wire aw_ok = i_awvalid && !aw_held_q && !o_bvalid;
   wire w_ok = i_wvalid && !w_held_q && !o_bvalid;
   assign o_awready = !aw_held_q && !o_bvalid;
   assign o_wready = !w_held_q && !o_bvalid;
   wire have_aw = aw_held_q || aw_ok;
   wire have_w = w_held_q || w_ok;
   wire do_write = have_aw && have_w;
   wire [3:0] wr_addr = aw_held_q ? awaddr_q : i_awaddr;
   wire [7:0] wr_byte = w_held_q ? wdata_q : i_wdata[7:0];
   wire wr_lane0 = w_held_q ? wstrb0_q : i_wstrb[0];
   wire wr_ctrl = do_write && wr_addr == csrl_pkg::CSRL_OFS_CONTROL;
   wire wr_pres = do_write && wr_addr == csrl_pkg::CSRL_OFS_PRESCALE;
   wire wr_hit = wr_ctrl || wr_pres;
   wire wr_ctrl_b = wr_ctrl && wr_lane0;
   wire wr_pres_b = wr_pres && wr_lane0;

   // Read data: unimplemented bits are zero
   wire [7:0] ctrl_rd = {ctrl_q.second_out_select, ctrl_q.first_out_select,
                         ctrl_q.cmp1_set_enable, ctrl_q.cmp2_reset_enable,
                         set_pulse_q, reset_pulse_q, 1'b0, ctrl_q.set_clock_enable};
   wire [7:0] pres_rd = {divider_q, 6'h00};
   wire rd_ctrl = i_araddr == csrl_pkg::CSRL_OFS_CONTROL;
   wire rd_pres = i_araddr == csrl_pkg::CSRL_OFS_PRESCALE;
   wire [31:0] rd_word = rd_ctrl ? {24'h000000, ctrl_rd} :
                         rd_pres ? {24'h000000, pres_rd} : 32'h00000000;
   assign o_arready = !o_rvalid;

   // Latch inputs; the comparator terms ignore comparator power state
   wire set_in = (ctrl_q.cmp1_set_enable && i_cmp1_output) || set_pulse_q || clk_pulse_q;
   wire reset_in = (ctrl_q.cmp2_reset_enable && i_cmp2_output) || reset_pulse_q;
   // Asynchronous core: comparator levels act at once, no clock needed
   wire latch_now = reset_in ? 1'b0 : (set_in ? 1'b1 : latch_q);

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awaddr_q <= 4'h0;
         wdata_q <= 8'h00;
         wstrb0_q <= 1'b0;
         o_bvalid <= 1'b0;
         o_bresp <= csrl_pkg::CSRL_RESP_OKAY;
         o_rvalid <= 1'b0;
         o_rdata <= 32'h00000000;
         o_rresp <= csrl_pkg::CSRL_RESP_OKAY;
      end else begin
         if (aw_ok) begin
            awaddr_q <= i_awaddr;
         end
         if (w_ok) begin
            wdata_q <= i_wdata[7:0];
            wstrb0_q <= i_wstrb[0];
         end
         aw_held_q <= have_aw && !do_write;
         w_held_q <= have_w && !do_write;
         if (do_write) begin
            o_bvalid <= 1'b1;
            o_bresp <= wr_hit ? csrl_pkg::CSRL_RESP_OKAY : csrl_pkg::CSRL_RESP_SLVERR;
         end else if (i_bready) begin
            o_bvalid <= 1'b0;
         end
         if (i_arvalid && !o_rvalid) begin
            o_rvalid <= 1'b1;
            o_rdata <= rd_word;
            o_rresp <= (rd_ctrl || rd_pres) ? csrl_pkg::CSRL_RESP_OKAY :
                       csrl_pkg::CSRL_RESP_SLVERR;
         end else if (i_rready) begin
            o_rvalid <= 1'b0;
         end
      end
   end

   // Control registers
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         ctrl_q <= '0;
         divider_q <= csrl_pkg::CSRL_DIVIDER_RESET;
         set_pulse_q <= 1'b0;
         reset_pulse_q <= 1'b0;
      end else begin
         if (wr_ctrl_b) begin
            ctrl_q.second_out_select <= wr_byte[csrl_pkg::CSRL_BIT_SECOND_OUT_SEL];
            ctrl_q.first_out_select <= wr_byte[csrl_pkg::CSRL_BIT_FIRST_OUT_SEL];
            ctrl_q.cmp1_set_enable <= wr_byte[csrl_pkg::CSRL_BIT_CMP1_SET_EN];
            ctrl_q.cmp2_reset_enable <= wr_byte[csrl_pkg::CSRL_BIT_CMP2_RESET_EN];
            ctrl_q.set_clock_enable <= wr_byte[csrl_pkg::CSRL_BIT_SET_CLOCK_ENABLE];
         end
         // Pulse bits: set only by a one, cleared by hardware next cycle
         set_pulse_q <= wr_ctrl_b && wr_byte[csrl_pkg::CSRL_BIT_SET_PULSE];
         reset_pulse_q <= wr_ctrl_b && wr_byte[csrl_pkg::CSRL_BIT_RESET_PULSE];
         if (wr_pres_b) begin
            divider_q <= wr_byte[7:csrl_pkg::CSRL_BIT_DIVIDER_LO];
         end
      end
   end

   // Set clock divider; counter restarts while disabled so first pulse is a full period
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst || !ctrl_q.set_clock_enable) begin
         div_cnt_q <= 7'h00;
         clk_pulse_q <= 1'b0;
      end else if (div_cnt_q >= div_max(divider_q)) begin
         div_cnt_q <= 7'h00;
         clk_pulse_q <= 1'b1;
      end else begin
         div_cnt_q <= div_cnt_q + 7'h01;
         clk_pulse_q <= 1'b0;
      end
   end

   // Holding element; latch_now is visible before the edge
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         latch_q <= 1'b0;
      end else begin
         latch_q <= latch_now;
      end
   end

   // Output routing and pin gating
   wire first_src = ctrl_q.first_out_select ? latch_now : i_cmp1_output;
   wire second_src = ctrl_q.second_out_select ? !latch_now : i_cmp2_output;
   assign o_pin_oe = i_cmp_pin_output_enable & ~i_pin_direction;
   assign o_pin_out = {second_src & o_pin_oe[1], first_src & o_pin_oe[0]};
   assign o_latch_q = latch_now;

   property p_reset_dominant;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (set_in && reset_in) |=> !latch_q;
   endproperty
   a_reset_dominant: assert property (p_reset_dominant) else $error("latch not reset");

   property p_set_wins_alone;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (set_in && !reset_in) |=> latch_q;
   endproperty
   a_set_wins_alone: assert property (p_set_wins_alone) else $error("latch not set");

   property p_pulse_one_cycle;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         set_pulse_q |=> !set_pulse_q || $past(wr_ctrl_b);
   endproperty
   a_pulse_one_cycle: assert property (p_pulse_one_cycle) else $error("pulse stuck");

   property p_no_clock_when_off;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         !ctrl_q.set_clock_enable |=> !clk_pulse_q;
   endproperty
   a_no_clock_when_off: assert property (p_no_clock_when_off) else $error("stray pulse");

   // Assertion helper: a divider write or a disable spoils the running period
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         period_upset_q <= 1'b0;
      end else if (wr_pres_b || !ctrl_q.set_clock_enable) begin
         period_upset_q <= 1'b1;
      end else if (clk_pulse_q) begin
         period_upset_q <= 1'b0;
      end
   end

   property p_div16_period;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (clk_pulse_q && ctrl_q.set_clock_enable && divider_q == 2'h0 && !wr_pres_b
          && !wr_ctrl_b) |=> !clk_pulse_q [*8] ##8 (clk_pulse_q || period_upset_q);
   endproperty
   a_div16_period: assert property (p_div16_period) else $error("bad period");

   property p_pin_gate;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (i_pin_direction[0] || !i_cmp_pin_output_enable[0]) |-> !o_pin_out[0] && !o_pin_oe[0];
   endproperty
   a_pin_gate: assert property (p_pin_gate) else $error("pin driven");

   property p_reserved_zero;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (o_rvalid && $rose(o_rvalid)) |-> o_rdata[1] == 1'b0 && o_rdata[31:8] == 24'h000000;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved set");

   property p_after_reset;
      @(posedge i_sys_clk) $fell(i_sys_rst) |-> ctrl_q == '0 && divider_q == 2'h0;
   endproperty
   a_after_reset: assert property (p_after_reset) else $error("bad reset");

   property p_clk_pulse_single;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         clk_pulse_q |=> !clk_pulse_q;
   endproperty
   a_clk_pulse_single: assert property (p_clk_pulse_single) else $error("long pulse");

   property p_reset_pulse_one;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         reset_pulse_q |=> !reset_pulse_q || $past(wr_ctrl_b);
   endproperty
   a_reset_pulse_one: assert property (p_reset_pulse_one) else $error("reset pulse stuck");

   property p_first_route;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (ctrl_q.first_out_select && o_pin_oe[0]) |-> o_pin_out[0] == o_latch_q;
   endproperty
   a_first_route: assert property (p_first_route) else $error("first pin not Q");

   property p_second_route;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (ctrl_q.second_out_select && o_pin_oe[1]) |-> o_pin_out[1] == !o_latch_q;
   endproperty
   a_second_route: assert property (p_second_route) else $error("second pin not Qbar");

   property p_pin_gate_hi;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (i_pin_direction[1] || !i_cmp_pin_output_enable[1]) |-> !o_pin_out[1] && !o_pin_oe[1];
   endproperty
   a_pin_gate_hi: assert property (p_pin_gate_hi) else $error("pin two driven");

   property p_cmp_reset_now;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (ctrl_q.cmp2_reset_enable && i_cmp2_output) |-> !o_latch_q;
   endproperty
   a_cmp_reset_now: assert property (p_cmp_reset_now) else $error("latch not cleared");

   property p_hold_idle;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (!set_in && !reset_in) |-> o_latch_q == latch_q;
   endproperty
   a_hold_idle: assert property (p_hold_idle) else $error("latch drifted");
endmodule : csrl_latch

// ===== tb/csrl_cmp_model.sv
// Comparator pair model: registered levels set by the bench.
// Assumes wanted levels change right after a clock edge.
module csrl_cmp_model (
   // Clock
   input wire logic i_sys_clk,
   // Wanted levels, bit0 comparator 1
   input wire logic [1:0] i_want,
   // Comparator outputs
   output logic o_cmp1,
   output logic o_cmp2
);
   timeunit 1ns;
   timeprecision 1ns;
   always @(posedge i_sys_clk) begin
      o_cmp1 <= i_want[0];
      o_cmp2 <= i_want[1];
   end
endmodule : csrl_cmp_model

// ===== tb/csrl_latch_tb_top.sv
// Bench for the comparator latch: bus master, latch model, set clock.
// Assumes csrl_pkg and the comparator model compile first.
module csrl_latch_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, qm = 0;
   logic [3:0] awa = 4'h0, ara = 4'h0;
   logic [31:0] wd = 32'h0, rdat;
   logic [1:0] want = 2'h0, en = 2'h0, dir = 2'h3, br, rr, pout, poe;
   logic aw_rdy, w_rdy, bv, ar_rdy, rv, c1, c2, q;
   logic [7:0] ctl = 8'h00;
   logic [7:0] pv [5] = '{8'h08, 8'h00, 8'h04, 8'h08, 8'h0c};
   int bad_count = 0, cmp_count = 0, seed = 32'h923e, cyc = 0, t1, n;
   always #25 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   csrl_cmp_model u_cmp (.i_sys_clk(clk), .i_want(want), .o_cmp1(c1), .o_cmp2(c2));
   csrl_latch dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_awaddr(awa), .i_awvalid(awv),
      .o_awready(aw_rdy), .i_wdata(wd), .i_wstrb(4'hf), .i_wvalid(wv), .o_wready(w_rdy),
      .o_bresp(br), .o_bvalid(bv), .i_bready(bre), .i_araddr(ara), .i_arvalid(arv),
      .o_arready(ar_rdy), .o_rdata(rdat), .o_rresp(rr), .o_rvalid(rv), .i_rready(rre),
      .i_cmp1_output(c1), .i_cmp2_output(c2), .i_cmp_pin_output_enable(en),
      .i_pin_direction(dir), .o_pin_out(pout), .o_pin_oe(poe), .o_latch_q(q));
   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task wrap_up;
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : wrap_up
   task wr(input logic [3:0] a, input logic [7:0] d);
      logic pa;
      logic pw;
      pa = 1;
      pw = 1;
      awa <= a;
      wd <= {24'h0, d};
      awv <= 1;
      wv <= 1;
      bre <= 1;
      while (pa || pw) begin
         @(posedge clk);
         if (pa && aw_rdy === 1'b1) begin
            pa = 0;
            awv <= 0;
         end
         if (pw && w_rdy === 1'b1) begin
            pw = 0;
            wv <= 0;
         end
      end
      do @(posedge clk); while (bv !== 1'b1);
      bre <= 0;
      check("bresp", 32'(br), 32'(csrl_pkg::CSRL_RESP_OKAY));
      @(posedge clk);
   endtask : wr
   task rd(input logic [3:0] a, input logic [7:0] e, input logic [1:0] er);
      ara <= a;
      arv <= 1;
      rre <= 1;
      do @(posedge clk); while (ar_rdy !== 1'b1);
      arv <= 0;
      do @(posedge clk); while (rv !== 1'b1);
      rre <= 0;
      check("rdata", rdat, {24'h0, e});
      check("rresp", 32'(rr), 32'(er));
      @(posedge clk);
   endtask : rd
   // Reset dominates, so it is tested first
   task upd;
      if (want[1] && ctl[4]) qm = 0;
      else if (want[0] && ctl[5]) qm = 1;
   endtask : upd
   task pins;
      logic [1:0] s;
      s = {ctl[7] ? ~qm : want[1], ctl[6] ? qm : want[0]};
      @(negedge clk);
      check("pin_oe", 32'(poe), 32'(en & ~dir));
      check("pin_out", 32'(pout), 32'(s & en & ~dir));
      check("latch_q", 32'(q), 32'(qm));
      @(posedge clk);
   endtask : pins
   // Sampled at edges, so both rises carry the same offset
   task wq;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (q !== 1'b1 && n < 300);
   endtask : wq
   initial begin
      repeat (5) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      rd(csrl_pkg::CSRL_OFS_CONTROL, 8'h00, csrl_pkg::CSRL_RESP_OKAY);
      rd(csrl_pkg::CSRL_OFS_PRESCALE, 8'h00, csrl_pkg::CSRL_RESP_OKAY);
      rd(4'h8, 8'h00, csrl_pkg::CSRL_RESP_SLVERR);
      en <= 2'h3;
      dir <= 2'h0;
      want <= 2'h1;
      @(posedge clk);
      pins;
      wr(csrl_pkg::CSRL_OFS_PRESCALE, 8'hff);
      rd(csrl_pkg::CSRL_OFS_PRESCALE, 8'hc0, csrl_pkg::CSRL_RESP_OKAY);
      wr(csrl_pkg::CSRL_OFS_CONTROL, 8'h02);
      rd(csrl_pkg::CSRL_OFS_CONTROL, 8'h00, csrl_pkg::CSRL_RESP_OKAY);
      repeat (24) begin
         n = $random(seed);
         wr(csrl_pkg::CSRL_OFS_CONTROL, {n[7:4], 4'h0});
         ctl = {n[7:4], 4'h0};
         upd;
         want <= n[9:8];
         en <= n[11:10];
         dir <= n[13:12];
         @(posedge clk);
         upd;
         pins;
      end
      want <= 2'h0;
      ctl = 8'h00;
      foreach (pv[i]) begin
         wr(csrl_pkg::CSRL_OFS_CONTROL, pv[i]);
         qm = pv[i][2] ? 1'b0 : (pv[i][3] ? 1'b1 : qm);
         check("pulse_q", 32'(q), 32'(qm));
      end
      rd(csrl_pkg::CSRL_OFS_CONTROL, 8'h00, csrl_pkg::CSRL_RESP_OKAY);
      for (int k = 0; k < 4; k++) begin
         wr(csrl_pkg::CSRL_OFS_PRESCALE, {k[1:0], 6'h00});
         wr(csrl_pkg::CSRL_OFS_CONTROL, 8'h04);
         wr(csrl_pkg::CSRL_OFS_CONTROL, 8'h11);
         wq;
         t1 = cyc;
         want <= 2'h2;
         @(posedge clk);
         want <= 2'h0;
         @(posedge clk);
         wq;
         check("set_period", cyc - t1, 16 << k);
      end
      wr(csrl_pkg::CSRL_OFS_CONTROL, 8'h04);
      n = 0;
      repeat (300) begin
         @(posedge clk);
         if (q !== 1'b0) n++;
      end
      check("idle_q", n, 0);
      wr(csrl_pkg::CSRL_OFS_CONTROL, 8'hf0);
      rst <= 1;
      repeat (2) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      rd(csrl_pkg::CSRL_OFS_CONTROL, 8'h00, csrl_pkg::CSRL_RESP_OKAY);
      ctl = 8'h00;
      qm = 0;
      pins;
      wrap_up;
   end
   // Whole run needs well under this many cycles
   initial begin
      #(60000 * 50);
      bad_count++;
      wrap_up;
   end
endmodule : csrl_latch_tb_top
